// ### bstap_pkg.sv
// Shared constants and types for the boundary-scan access port
package bstap_pkg;

    localparam int IR_W   = 8;
    localparam int BSR_W  = 40;
    localparam int BCR_W  = 11;
    localparam int RESET_HOLD = 5;

    localparam logic [IR_W-1:0]  IR_RESET_VAL  = 8'hff;
    localparam logic [IR_W-1:0]  IR_CAPT_VAL   = 8'h81;
    localparam logic [BCR_W-1:0] BCR_RESET_VAL = 11'h002;
    localparam logic [BSR_W-1:0] BSR_RESET_VAL = 40'h00_0000_0000;

    // Opcodes, even parity in bit 7; values below are arbitrary
    localparam logic [IR_W-1:0] OP_BYPASS  = 8'hff;
    localparam logic [IR_W-1:0] OP_EXTEST  = 8'h00;
    localparam logic [IR_W-1:0] OP_SAMPLE  = 8'h82;
    localparam logic [IR_W-1:0] OP_BCRSCAN = 8'h87;
    localparam logic [IR_W-1:0] OP_RUNTEST = 8'h09;

    // Test-operation field of the control register
    localparam int            BCR_OP_LSB = 0;
    localparam logic [1:0]    BCR_OP_ISC = 2'h2;
    localparam int            BCR_MASK_BIT = 2;

    // Signature feedback taps
    localparam int TAP_A = 39;
    localparam int TAP_B = 37;
    localparam int TAP_C = 20;
    localparam int TAP_D = 18;

    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h2,
        ST_CAPT_DR  = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR   = 4'h8,
        ST_SEL_IR   = 4'h9,
        ST_CAPT_IR  = 4'ha,
        ST_SHIFT_IR = 4'hb,
        ST_EXIT1_IR = 4'hc,
        ST_PAUSE_IR = 4'hd,
        ST_EXIT2_IR = 4'he,
        ST_UPD_IR   = 4'hf
    } bstap_state_t;

    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_BSR    = 2'h1,
        SEL_BCR    = 2'h2
    } bstap_sel_t;

endpackage

// ### bstap_sync.sv
// Three-stage input synchroniser with debounced level and edge pulses
`timescale 1ns/100ps
module bstap_sync #(
    parameter int W = 3
) (
    input  wire logic         sys_clk_in,
    input  wire logic         reset_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] rise_out,
    output logic      [W-1:0] fall_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk_in) begin
                if (reset_in) begin
                    s1_r[i]      <= 1'b0;
                    s2_r[i]      <= 1'b0;
                    s3_r[i]      <= 1'b0;
                    level_out[i] <= 1'b0;
                    rise_out[i]  <= 1'b0;
                    fall_out[i]  <= 1'b0;
                end else begin
                    s1_r[i] <= async_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    // A change counts only once stages two and three agree
                    if (s2_r[i] == s3_r[i]) begin
                        level_out[i] <= s3_r[i];
                    end
                    rise_out[i] <= (s2_r[i] == s3_r[i]) && s3_r[i] && !level_out[i];
                    fall_out[i] <= (s2_r[i] == s3_r[i]) && !s3_r[i] && level_out[i];
                end
            end
        end
    endgenerate
endmodule

// ### bstap_tap.sv
// Boundary-scan test access port: controller, scan registers and serial output
`timescale 1ns/100ps
module bstap_tap (
    input  wire logic                        sys_clk_in,
    input  wire logic                        reset_in,
    input  wire logic                        tck_in,
    input  wire logic                        tms_in,
    input  wire logic                        tdi_in,
    input  wire logic [bstap_pkg::BSR_W-1:0] pins_in,
    output logic                             tdo_out,
    output logic                             tdo_oe_out,
    output logic                             test_mode_out,
    output logic                             run_test_out,
    output bstap_pkg::bstap_state_t          state_out,
    output logic [bstap_pkg::IR_W-1:0]       instr_out,
    output logic [bstap_pkg::BSR_W-1:0]      bsr_out,
    output logic [bstap_pkg::BCR_W-1:0]      bcr_out
);
    import bstap_pkg::*;

    logic [2:0]       lvl;
    logic [2:0]       rise;
    logic [2:0]       fall;
    logic             tck_rise;
    logic             tck_fall;
    logic             tms_lvl;
    logic             tdi_lvl;

    bstap_state_t     state_r;
    bstap_state_t     state_nxt;
    // Eight-bit instruction, 40-bit boundary, 11-bit control and 1-bit bypass stages
    logic [IR_W-1:0]  ir_sh_r;
    logic [IR_W-1:0]  ir_r;
    logic [BSR_W-1:0] bsr_sh_r;
    logic [BSR_W-1:0] bsr_r;
    logic [BCR_W-1:0] bcr_sh_r;
    logic [BCR_W-1:0] bcr_r;
    logic             byp_r;
    bstap_sel_t       sel;
    logic             dr_lsb;
    logic             sig_fb;
    logic             run_en;

    bstap_sync #(
        .W (3)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .async_in   ({tdi_in, tms_in, tck_in}),
        .level_out  (lvl),
        .rise_out   (rise),
        .fall_out   (fall)
    );

    assign tck_rise = rise[0];
    assign tck_fall = fall[0];
    assign tms_lvl  = lvl[1];
    assign tdi_lvl  = lvl[2];

    // Data register chosen by the current instruction; unknown codes act as bypass
    always_comb begin
        case (ir_r)
            OP_EXTEST:  sel = SEL_BSR;
            OP_SAMPLE:  sel = SEL_BSR;
            OP_RUNTEST: sel = SEL_BSR;
            OP_BCRSCAN: sel = SEL_BCR;
            default:    sel = SEL_BYPASS;
        endcase
    end

    // Only the selected register feeds the serial output
    always_comb begin
        case (sel)
            SEL_BSR: dr_lsb = bsr_sh_r[0];
            SEL_BCR: dr_lsb = bcr_sh_r[0];
            default: dr_lsb = byp_r;
        endcase
    end

    // Standard scan state graph; five high rises reach reset
    always_comb begin
        case (state_r)
            ST_RESET:    state_nxt = tms_lvl ? ST_RESET    : ST_IDLE;
            ST_IDLE:     state_nxt = tms_lvl ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   state_nxt = tms_lvl ? ST_SEL_IR   : ST_CAPT_DR;
            ST_CAPT_DR:  state_nxt = tms_lvl ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_nxt = tms_lvl ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_nxt = tms_lvl ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_nxt = tms_lvl ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_nxt = tms_lvl ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_nxt = tms_lvl ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   state_nxt = tms_lvl ? ST_RESET    : ST_CAPT_IR;
            ST_CAPT_IR:  state_nxt = tms_lvl ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_nxt = tms_lvl ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_nxt = tms_lvl ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_nxt = tms_lvl ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_nxt = tms_lvl ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_nxt = tms_lvl ? ST_SEL_DR   : ST_IDLE;
            default:     state_nxt = ST_RESET;
        endcase
    end

    // Controller moves only on a test-clock rise
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_r <= ST_RESET;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

    // Instruction shift stage: capture status, then shift
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            ir_sh_r <= IR_RESET_VAL;
        end else if (tck_rise) begin
            if (state_r == ST_CAPT_IR) begin
                ir_sh_r <= IR_CAPT_VAL;
            end else if (state_r == ST_SHIFT_IR) begin
                ir_sh_r <= {tdi_lvl, ir_sh_r[IR_W-1:1]};
            end
        end
    end

    // Current instruction; reset to bypass, updated on the fall
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            ir_r <= IR_RESET_VAL;
        end else if (state_r == ST_RESET) begin
            ir_r <= IR_RESET_VAL;
        end else if (tck_fall && state_r == ST_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // Data shift stages: capture on the leaving rise, shift one bit per rise
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            bsr_sh_r <= BSR_RESET_VAL;
            bcr_sh_r <= BCR_RESET_VAL;
            byp_r    <= 1'b0;
        end else if (state_r == ST_RESET) begin
            bsr_sh_r <= BSR_RESET_VAL;
            bcr_sh_r <= BCR_RESET_VAL;
            byp_r    <= 1'b0;
        end else if (tck_rise && state_r == ST_CAPT_DR) begin
            case (sel)
                SEL_BSR: bsr_sh_r <= (ir_r == OP_RUNTEST) ? bsr_r : pins_in;
                SEL_BCR: bcr_sh_r <= bcr_r;
                default: byp_r    <= 1'b0;
            endcase
        end else if (tck_rise && state_r == ST_SHIFT_DR) begin
            case (sel)
                SEL_BSR: bsr_sh_r <= {tdi_lvl, bsr_sh_r[BSR_W-1:1]};
                SEL_BCR: bcr_sh_r <= {tdi_lvl, bcr_sh_r[BCR_W-1:1]};
                default: byp_r    <= tdi_lvl;
            endcase
        end
    end

    assign run_en = (state_r == ST_IDLE) && (ir_r == OP_RUNTEST)
                    && (bcr_r[BCR_OP_LSB +: 2] == BCR_OP_ISC);
    assign sig_fb = bsr_r[TAP_A] ^ bsr_r[TAP_B] ^ bsr_r[TAP_C] ^ bsr_r[TAP_D];

    // Boundary shadow: reset, update on the fall, signature compaction in idle
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            bsr_r <= BSR_RESET_VAL;
        end else if (state_r == ST_RESET) begin
            bsr_r <= BSR_RESET_VAL;
        end else if (tck_fall && state_r == ST_UPD_DR && sel == SEL_BSR) begin
            bsr_r <= bsr_sh_r;
        end else if (tck_rise && run_en) begin
            if (bcr_r[BCR_MASK_BIT]) begin
                bsr_r <= {bsr_r[BSR_W-2:0], sig_fb};
            end else begin
                bsr_r <= {bsr_r[BSR_W-2:0], sig_fb} ^ pins_in;
            end
        end
    end

    // Control register shadow
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            bcr_r <= BCR_RESET_VAL;
        end else if (state_r == ST_RESET) begin
            bcr_r <= BCR_RESET_VAL;
        end else if (tck_fall && state_r == ST_UPD_DR && sel == SEL_BCR) begin
            bcr_r <= bcr_sh_r;
        end
    end

    // Serial output changes on the fall only
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            case (state_r)
                ST_SHIFT_DR: begin
                    tdo_out    <= dr_lsb;
                    tdo_oe_out <= 1'b1;
                end
                ST_SHIFT_IR: begin
                    tdo_out    <= ir_sh_r[0];
                    tdo_oe_out <= 1'b1;
                end
                default: begin
                    tdo_out    <= 1'b0;
                    tdo_oe_out <= 1'b0;
                end
            endcase
        end
    end

    // Status outputs; test mode is off while in reset state
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            test_mode_out <= 1'b0;
            run_test_out  <= 1'b0;
            state_out     <= ST_RESET;
            instr_out     <= IR_RESET_VAL;
            bsr_out       <= BSR_RESET_VAL;
            bcr_out       <= BCR_RESET_VAL;
        end else begin
            test_mode_out <= (state_r != ST_RESET)
                             && (ir_r == OP_EXTEST || ir_r == OP_RUNTEST);
            run_test_out  <= run_en;
            state_out     <= state_r;
            instr_out     <= ir_r;
            bsr_out       <= bsr_r;
            bcr_out       <= bcr_r;
        end
    end

    // Checks
    logic [2:0] tms_hi_cnt_r;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tms_hi_cnt_r <= 3'h0;
        end else if (tck_rise) begin
            if (!tms_lvl) begin
                tms_hi_cnt_r <= 3'h0;
            end else if (tms_hi_cnt_r != 3'h7) begin
                tms_hi_cnt_r <= tms_hi_cnt_r + 3'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    state_on_rise_a: assert property (!tck_rise |=> $stable(state_r))
        else $error("state moved without a test-clock rise");
    five_high_a: assert property (tms_hi_cnt_r >= 3'h5 |-> state_r == ST_RESET)
        else $error("five high mode-select rises did not reach reset");
    reset_values_a: assert property (state_r == ST_RESET |=>
        ir_r == IR_RESET_VAL && bcr_r == BCR_RESET_VAL && bsr_r == BSR_RESET_VAL)
        else $error("reset state did not restore register values");
    select_leave_a: assert property (tck_rise && state_r == ST_SEL_DR |=>
        state_r == ST_CAPT_DR || state_r == ST_SEL_IR)
        else $error("select state not left correctly");
    ir_capture_a: assert property (tck_rise && state_r == ST_CAPT_IR |=>
        ir_sh_r == IR_CAPT_VAL)
        else $error("status pattern not captured");
    ir_shift_a: assert property (tck_rise && state_r == ST_SHIFT_IR |=>
        ir_sh_r == {$past(tdi_lvl), $past(ir_sh_r[IR_W-1:1])})
        else $error("instruction shift wrong");
    ir_update_a: assert property (tck_fall && state_r == ST_UPD_IR |=>
        ir_r == $past(ir_sh_r))
        else $error("instruction not updated on fall");
    tdo_enable_a: assert property (tck_fall |=>
        tdo_oe_out == ($past(state_r) == ST_SHIFT_DR || $past(state_r) == ST_SHIFT_IR))
        else $error("serial output enable wrong after fall");
    tdo_quiet_a: assert property (!tck_fall |=> $stable(tdo_out) && $stable(tdo_oe_out))
        else $error("serial output changed off the falling edge");
    run_idle_a: assert property (run_test_out |-> $past(state_r) == ST_IDLE)
        else $error("test operation outside idle");

    // Scan-path checks
    bsr_shift_a: assert property (tck_rise && state_r == ST_SHIFT_DR && sel == SEL_BSR |=>
        bsr_sh_r == {$past(tdi_lvl), $past(bsr_sh_r[BSR_W-1:1])})
        else $error("boundary shift wrong");
    byp_shift_a: assert property (tck_rise && state_r == ST_SHIFT_DR && sel == SEL_BYPASS |=>
        byp_r == $past(tdi_lvl))
        else $error("bypass shift wrong");
    bcr_capture_a: assert property (tck_rise && state_r == ST_CAPT_DR && sel == SEL_BCR |=>
        bcr_sh_r == $past(bcr_r))
        else $error("control register not captured");
    pins_capture_a: assert property (tck_rise && state_r == ST_CAPT_DR && sel == SEL_BSR
        && ir_r != OP_RUNTEST |=> bsr_sh_r == $past(pins_in))
        else $error("pin values not captured");
    bsr_update_a: assert property (tck_fall && state_r == ST_UPD_DR && sel == SEL_BSR |=>
        bsr_r == $past(bsr_sh_r))
        else $error("boundary shadow not updated on fall");
    bcr_update_a: assert property (tck_fall && state_r == ST_UPD_DR && sel == SEL_BCR |=>
        bcr_r == $past(bcr_sh_r))
        else $error("control shadow not updated on fall");
    tdo_data_a: assert property (tck_fall && state_r == ST_SHIFT_DR |=>
        tdo_out == $past(dr_lsb))
        else $error("serial output not the data register low bit");
    tdo_instr_a: assert property (tck_fall && state_r == ST_SHIFT_IR |=>
        tdo_out == $past(ir_sh_r[0]))
        else $error("serial output not the instruction low bit");
    ir_hold_a: assert property (!(tck_fall && state_r == ST_UPD_IR) && state_r != ST_RESET |=>
        $stable(ir_r))
        else $error("instruction changed outside update");
    reset_quiet_a: assert property (state_r == ST_RESET |=>
        !test_mode_out && !run_test_out)
        else $error("test logic active in reset state");
    sel_ir_leave_a: assert property (tck_rise && state_r == ST_SEL_IR |=>
        state_r == ST_CAPT_IR || state_r == ST_RESET)
        else $error("instruction select state not left correctly");

    shift_dr_c: cover property (state_r == ST_SHIFT_DR && tck_fall ##1 tdo_oe_out);
    upd_ir_c: cover property (state_r == ST_UPD_IR && tck_fall);
    run_c: cover property (run_test_out);
    ir_shift_c: cover property (state_r == ST_SHIFT_IR && tck_rise);
    masked_run_c: cover property (run_test_out && bcr_r[BCR_MASK_BIT]);
endmodule

// ### bstap_ctl_model.sv
// Board-level scan controller model that drives the test access port
`timescale 1ns/100ps
module bstap_ctl_model (
    input  wire logic sys_clk_in,
    input  wire logic tdo_in,
    input  wire logic tdo_oe_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    // Half period of the test clock in system clocks, 160 ns period
    localparam int HALF = 8;

    // Clock starts low; tms and tdi rest at their pull-up level
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end

    // One test-clock cycle: lines change on the fall, tdo is read just before the rise
    task automatic tck_cycle(input logic tms_v, input logic tdi_v, output logic tdo_v, output logic oe_v);
        @(posedge sys_clk_in);
        tck_out <= 1'b0;
        tms_out <= tms_v;
        tdi_out <= tdi_v;
        repeat (HALF) @(posedge sys_clk_in);
        // An undriven line reads inverted so a missing enable shows up as a bit error
        tdo_v = tdo_oe_in ? tdo_in : ~tdo_in;
        oe_v  = tdo_oe_in;
        tck_out <= 1'b1;
        repeat (HALF - 1) @(posedge sys_clk_in);
    endtask
endmodule

// ### bstap_tap_tb_top.sv
// Self-checking testbench for the boundary-scan access port
`timescale 1ns/100ps
module bstap_tap_tb_top;
    import bstap_pkg::*;
    logic             sys_clk = 1'b0;
    logic             reset   = 1'b1;
    logic             tck;
    logic             tms;
    logic             tdi;
    logic [BSR_W-1:0] pins    = '0;
    logic             tdo;
    logic             tdo_oe;
    logic             test_mode;
    logic             run_test;
    bstap_state_t     state;
    logic [IR_W-1:0]  instr;
    logic [BSR_W-1:0] bsr;
    logic [BCR_W-1:0] bcr;
    logic [63:0]      dout;
    int               n_errors = 0;
    int               n_checks = 0;

    always #5 sys_clk = ~sys_clk;

    bstap_tap dut (.sys_clk_in(sys_clk), .reset_in(reset), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
                   .pins_in(pins), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .test_mode_out(test_mode),
                   .run_test_out(run_test), .state_out(state), .instr_out(instr), .bsr_out(bsr),
                   .bcr_out(bcr));

    bstap_ctl_model ctl (.sys_clk_in(sys_clk), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck),
                         .tms_out(tms), .tdi_out(tdi));

    task automatic complete_run();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_bits(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One spare cycle lets the registered state copy settle
    task automatic check_state(input bstap_state_t exp);
        @(posedge sys_clk);
        n_checks++;
        if (state !== exp) begin
            n_errors++;
            $display("Error state expected %h seen %h", exp, state);
        end
    endtask

    task automatic step(input logic m);
        logic o;
        logic e;
        ctl.tck_cycle(m, 1'b1, o, e);
    endtask

    // From idle: select, capture, shift n bits LSB first, update, back to idle
    task automatic scan_reg(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dq);
        logic o;
        logic e;
        step(1'b1);
        if (ir) begin
            step(1'b1);
        end
        step(1'b0);
        ctl.tck_cycle(1'b0, 1'b1, o, e);
        check_bits("tdo_oe in capture", 64'h0, e);
        dq = '0;
        for (int i = 0; i < n; i++) begin
            ctl.tck_cycle(i == n - 1, din[i], o, e);
            check_bits("tdo_oe in shift", 64'h1, e);
            dq[i] = o;
        end
        ctl.tck_cycle(1'b1, 1'b1, o, e);
        check_bits("tdo_oe in exit1", 64'h0, e);
        step(1'b0);
    endtask

    function automatic logic [BSR_W-1:0] sig_step(input logic [BSR_W-1:0] b, input logic [BSR_W-1:0] p);
        return {b[BSR_W-2:0], b[TAP_A] ^ b[TAP_B] ^ b[TAP_C] ^ b[TAP_D]} ^ p;
    endfunction

    task automatic t_reset_values();
        check_state(ST_RESET);
        check_bits("instr", IR_RESET_VAL, instr);
        check_bits("bsr", BSR_RESET_VAL, bsr);
        check_bits("bcr", BCR_RESET_VAL, bcr);
        check_bits("test_mode", 64'h0, test_mode);
        check_bits("tdo_oe", 64'h0, tdo_oe);
    endtask

    task automatic t_graph();
        logic         m [24] = '{0, 0, 1, 0, 0, 1, 0, 0, 1, 0, 1, 1, 1, 1, 0, 1, 0, 1, 1, 0, 1, 1, 1, 1};
        bstap_state_t s [24] = '{ST_IDLE, ST_IDLE, ST_SEL_DR, ST_CAPT_DR, ST_SHIFT_DR, ST_EXIT1_DR,
                                 ST_PAUSE_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_SHIFT_DR, ST_EXIT1_DR,
                                 ST_UPD_DR, ST_SEL_DR, ST_SEL_IR, ST_CAPT_IR, ST_EXIT1_IR, ST_PAUSE_IR,
                                 ST_EXIT2_IR, ST_UPD_IR, ST_IDLE, ST_SEL_DR, ST_SEL_IR, ST_RESET, ST_RESET};
        for (int i = 0; i < 24; i++) begin
            step(m[i]);
            check_state(s[i]);
        end
        step(1'b0);
    endtask

    task automatic t_ir_extest();
        scan_reg(1'b1, {56'h0, OP_EXTEST}, 8, dout);
        check_bits("ir capture", IR_CAPT_VAL, dout[7:0]);
        check_bits("instr", OP_EXTEST, instr);
        check_bits("test_mode", 64'h1, test_mode);
    endtask

    task automatic t_bsr_scan();
        @(posedge sys_clk);
        pins <= 40'h5a_c30f_96e1;
        scan_reg(1'b0, 64'h0000_c3a5_1234_5678, 48, dout);
        check_bits("bsr capture", 40'h5a_c30f_96e1, dout[39:0]);
        check_bits("bsr length", 64'h78, dout[47:40]);
        check_bits("bsr update", 40'hc3_a512_3456, bsr);
    endtask

    task automatic t_bcr_scan();
        scan_reg(1'b1, {56'h0, OP_BCRSCAN}, 8, dout);
        scan_reg(1'b0, 64'h001, 11, dout);
        check_bits("bcr out", BCR_RESET_VAL, dout[10:0]);
        check_bits("bcr", 64'h001, bcr);
        scan_reg(1'b0, {53'h0, BCR_RESET_VAL}, 11, dout);
        check_bits("bcr out", 64'h001, dout[10:0]);
        check_bits("bcr", BCR_RESET_VAL, bcr);
    endtask

    task automatic t_runtest();
        logic [BSR_W-1:0] b0;
        scan_reg(1'b1, {56'h0, OP_RUNTEST}, 8, dout);
        b0 = bsr;
        step(1'b0);
        check_state(ST_IDLE);
        check_bits("run_test idle", 64'h1, run_test);
        check_bits("signature", sig_step(b0, pins), bsr);
        step(1'b1);
        check_state(ST_SEL_DR);
        check_bits("run_test select", 64'h0, run_test);
    endtask

    // From select-DR to pause-IR, then five highs must reach reset and no fewer
    task automatic t_tms_reset();
        step(1'b1);
        step(1'b0);
        step(1'b1);
        step(1'b0);
        check_state(ST_PAUSE_IR);
        repeat (4) step(1'b1);
        check_state(ST_SEL_IR);
        step(1'b1);
        check_state(ST_RESET);
        check_bits("instr", IR_RESET_VAL, instr);
        check_bits("bsr", BSR_RESET_VAL, bsr);
        check_bits("bcr", BCR_RESET_VAL, bcr);
        check_bits("run_test", 64'h0, run_test);
    endtask

    task automatic t_bypass();
        step(1'b0);
        check_state(ST_IDLE);
        scan_reg(1'b0, 64'hb4, 8, dout);
        check_bits("bypass out", 64'h68, dout[7:0]);
    endtask

    // Sample keeps test mode off; masked compaction leaves the pins out of the signature
    task automatic t_sample_mask();
        logic [BSR_W-1:0] b0;
        logic [BCR_W-1:0] mval;
        mval = BCR_RESET_VAL;
        mval[BCR_MASK_BIT] = 1'b1;
        scan_reg(1'b1, {56'h0, OP_SAMPLE}, 8, dout);
        check_bits("instr sample", OP_SAMPLE, instr);
        check_bits("test_mode sample", 64'h0, test_mode);
        scan_reg(1'b0, 64'h80_0010_0001, 40, dout);
        check_bits("sample capture", 40'h5a_c30f_96e1, dout[39:0]);
        check_bits("sample update", 40'h80_0010_0001, bsr);
        scan_reg(1'b1, {56'h0, OP_BCRSCAN}, 8, dout);
        scan_reg(1'b0, {53'h0, mval}, 11, dout);
        check_bits("bcr mask", mval, bcr);
        scan_reg(1'b1, {56'h0, OP_RUNTEST}, 8, dout);
        b0 = bsr;
        step(1'b0);
        check_state(ST_IDLE);
        check_bits("run_test masked", 64'h1, run_test);
        check_bits("masked signature", sig_step(b0, '0), bsr);
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_reset_values();
        t_graph();
        t_ir_extest();
        t_bsr_scan();
        t_bcr_scan();
        t_runtest();
        t_tms_reset();
        t_bypass();
        t_sample_mask();
        complete_run();
    end
endmodule
